/* logic/sysint_pkg.sv */
// package for the system integrity monitor: register layout and reset values
// assumes a single 10 MHz system clock and a 32-bit avalon-mm register bus
package sysint_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] SIM_OFS_CTRL   = 4'h0;  // paged control/status register
  localparam logic [3:0] SIM_OFS_EVENT  = 4'h4;  // interrupt request and wake status
  localparam logic [3:0] SIM_OFS_STRAP  = 4'h8;  // option straps as read back
  // shared bit
  localparam int SIM_BIT_PAGE       = 7;
  // page 0 fields
  localparam int SIM_BIT_SW_IE      = 6;
  localparam int SIM_BIT_SW_FLAG    = 5;
  localparam int SIM_BIT_UV_RF      = 4;
  localparam int SIM_BIT_CF_IE      = 2;
  localparam int SIM_BIT_SAFE_FLAG  = 1;
  localparam int SIM_BIT_WD_RF      = 0;
  // page 1 fields
  localparam int SIM_BIT_VCO_GND    = 5;
  localparam int SIM_BIT_LOCK       = 4;
  localparam int SIM_BIT_PLL_EN     = 3;
  localparam int SIM_BIT_CKSRC      = 1;
  // event register fields
  localparam int SIM_BIT_EV_SWIRQ   = 0;
  localparam int SIM_BIT_EV_CFIRQ   = 1;
  localparam int SIM_BIT_EV_WAKE    = 2;
  // reset values
  localparam logic [7:0] SIM_RST_PAGE0 = 8'h00;
  localparam logic [7:0] SIM_RST_PAGE1 = 8'h00;
  // reset delay counts selectable by option, in cpu cycles
  localparam int SIM_RST_DLY_SHORT  = 256;
  localparam int SIM_RST_DLY_LONG   = 4096;
  // bus access state machine, gray coded
  typedef enum logic [1:0] {
    SIM_IDLE = 2'b00,
    SIM_ACK  = 2'b01
  } sim_bus_t;
endpackage : sysint_pkg

/* logic/sysint_monitor.sv */
// system integrity monitor: supply warning irq, clock guard, reset flags, paged register
// assumes synchronous inputs, an avalon-mm master and reset cause pulses from the reset manager
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sysint_monitor
  import sysint_pkg::*;
#(
  parameter int RST_DELAY_SHORT = sysint_pkg::SIM_RST_DLY_SHORT,
  parameter int RST_DELAY_LONG  = sysint_pkg::SIM_RST_DLY_LONG
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        CLK_EN,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic      [1:0]  AVS_RESPONSE,
  // analog and system status
  input  wire logic        SUPPLY_BELOW,
  input  wire logic        MAIN_CLK_LOST,
  input  wire logic        PLL_LOCKED,
  input  wire logic        UV_RESET_EVT,
  input  wire logic        WD_RESET_EVT,
  input  wire logic        LONG_DELAY_OPT,
  input  wire logic        PROG_SESSION,
  input  wire logic        CPU_IRQ_MASK,
  input  wire logic        SW_IRQ_ACK,
  input  wire logic        CPU_WAIT,
  input  wire logic        CPU_HALT,
  input  wire logic        ACTIVE_HALT,
  // outputs
  output logic             SUPPLY_IRQ,
  output logic             CLOCK_IRQ,
  output logic             WAKE_REQ,
  output logic             PLL_ENABLE,
  output logic             VCO_GROUNDED,
  output logic             PLL_CLK_SELECT,
  output logic             SAFE_OSC_SELECT
);
  import sysint_pkg::*;

  initial
  begin
    if (RST_DELAY_SHORT < 1 || RST_DELAY_LONG < RST_DELAY_SHORT || RST_DELAY_LONG > 65535)
      $error("sysint_monitor: unusable reset delay parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic       page_r;
  logic       sw_ie_r;
  logic       uv_rf_r;
  logic       cf_ie_r;
  logic       safe_r;
  logic       wd_rf_r;
  logic       vco_gnd_r;
  logic       pll_en_r;
  logic       cksrc_r;
  logic       sw_flag_r;
  logic       sw_pend_r;
  logic       safe_pend_r;
  logic [15:0] dly_cnt_r;
  logic       dly_done_r;
  sim_bus_t   bus_st_r;
  logic [31:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        req       = (AVS_READ | AVS_WRITE) & (bus_st_r == SIM_IDLE);
  wire        hit_ctrl  = (AVS_ADDRESS == SIM_OFS_CTRL);
  wire        hit_event = (AVS_ADDRESS == SIM_OFS_EVENT);
  wire        hit_strap = (AVS_ADDRESS == SIM_OFS_STRAP);
  wire        mapped    = hit_ctrl | hit_event | hit_strap;
  wire        wr_ctrl   = req & AVS_WRITE & hit_ctrl & AVS_BYTEENABLE[0];
  wire        rd_ctrl   = req & AVS_READ & hit_ctrl;
  wire [7:0]  wd        = AVS_WRITEDATA[7:0];

  // clock guard only works when the pll runs and the cpu is not in full halt
  wire guard_on   = pll_en_r & ~(CPU_HALT & ~ACTIVE_HALT);
  wire safe_take  = guard_on & MAIN_CLK_LOST;
  wire safe_vis   = safe_r & pll_en_r;
  // read clears only once the original oscillator is back
  wire safe_clr   = rd_ctrl & ~page_r & ~MAIN_CLK_LOST;

  // warning comparator stays live in every mode, including halt
  wire sw_toggle  = (SUPPLY_BELOW != sw_flag_r);
  wire sw_en_rise = wr_ctrl & ~page_r & wd[SIM_BIT_SW_IE] & ~sw_ie_r;
  // events during the start-up delay are suppressed
  wire sw_event   = dly_done_r & sw_ie_r & sw_toggle;
  wire sw_set     = sw_event | (sw_en_rise & dly_done_r);

  wire cf_req     = safe_pend_r & cf_ie_r & pll_en_r & ~CPU_IRQ_MASK;
  wire sw_req     = sw_pend_r & ~CPU_IRQ_MASK;
  // wait keeps everything running; full halt ignores the clock irq
  wire wake_nxt   = (CPU_WAIT & (sw_pend_r | cf_req))
                  | (CPU_HALT & sw_pend_r)
                  | (CPU_HALT & ACTIVE_HALT & cf_req);

  // page 1 write with the select/disable interlock
  wire p1_wr      = wr_ctrl & page_r;
  wire pll_en_w   = wd[SIM_BIT_PLL_EN] | (cksrc_r & wd[SIM_BIT_CKSRC]);
  wire cksrc_w    = wd[SIM_BIT_CKSRC] & pll_en_w;

  wire [15:0] dly_target = LONG_DELAY_OPT ? 16'(RST_DELAY_LONG) : 16'(RST_DELAY_SHORT);

  wire [7:0] page0_view = {page_r, sw_ie_r, sw_flag_r, uv_rf_r,
                           1'b0, cf_ie_r, safe_vis, wd_rf_r};
  wire [7:0] page1_view = {page_r, 1'b0, vco_gnd_r, PLL_LOCKED,
                           pll_en_r, 1'b0, cksrc_r, 1'b0};
  wire [7:0] ctrl_view  = page_r ? page1_view : page0_view;
  wire [31:0] rd_mux    = hit_ctrl  ? {24'h000000, ctrl_view} :
                          hit_event ? {29'h0, WAKE_REQ, CLOCK_IRQ, SUPPLY_IRQ} :
                          hit_strap ? {30'h0, PROG_SESSION, LONG_DELAY_OPT} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      bus_st_r        <= SIM_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
      AVS_RESPONSE    <= 2'h0;
    end
    else if (CLK_EN)
    begin
      if (req)
      begin
        bus_st_r        <= SIM_ACK;
        AVS_WAITREQUEST <= 1'b0;
        AVS_READDATA    <= AVS_READ ? rd_mux : 32'h00000000;
        AVS_RESPONSE    <= mapped ? 2'h0 : 2'h2;   // slave error on unmapped word
      end
      else
      begin
        bus_st_r        <= SIM_IDLE;
        AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset delay counter: warning events wait until it expires
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      dly_cnt_r  <= 16'h0000;
      dly_done_r <= 1'b0;
      sw_flag_r  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (!dly_done_r)
      begin
        dly_cnt_r <= dly_cnt_r + 16'h0001;
        if (dly_cnt_r + 16'h0001 >= dly_target)
          dly_done_r <= 1'b1;
      end
      sw_flag_r <= SUPPLY_BELOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page 0 and pending events
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      page_r      <= SIM_RST_PAGE0[SIM_BIT_PAGE];
      sw_ie_r     <= SIM_RST_PAGE0[SIM_BIT_SW_IE];
      cf_ie_r     <= SIM_RST_PAGE0[SIM_BIT_CF_IE];
      safe_r      <= SIM_RST_PAGE0[SIM_BIT_SAFE_FLAG];
      sw_pend_r   <= 1'b0;
      safe_pend_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (wr_ctrl)
        page_r <= wd[SIM_BIT_PAGE];
      if (wr_ctrl && !page_r)
      begin
        sw_ie_r <= wd[SIM_BIT_SW_IE];
        cf_ie_r <= wd[SIM_BIT_CF_IE];
      end
      // set wins over clear on every hardware flag
      if (safe_take)
        safe_r <= 1'b1;
      else if (safe_clr || !pll_en_r)
        safe_r <= 1'b0;
      if (safe_take && !safe_r)
        safe_pend_r <= 1'b1;
      else if (safe_clr || !pll_en_r)
        safe_pend_r <= 1'b0;
      if (sw_set)
        sw_pend_r <= 1'b1;
      else if (SW_IRQ_ACK)
        sw_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags; they live across system reset, so only the events and page 0 writes of zero move them
  always_ff @(posedge CLK_SYS)
  begin
    if (UV_RESET_EVT)
    begin
      uv_rf_r <= 1'b1;
      wd_rf_r <= 1'b0;
    end
    else
    begin
      if (WD_RESET_EVT)
        wd_rf_r <= 1'b1;
      else if (CLK_EN && NRST && wr_ctrl && !page_r && !wd[SIM_BIT_WD_RF])
        wd_rf_r <= 1'b0;
      if (CLK_EN && NRST && wr_ctrl && !page_r && !wd[SIM_BIT_UV_RF])
        uv_rf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page 1 pll controls
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      vco_gnd_r <= SIM_RST_PAGE1[SIM_BIT_VCO_GND];
      pll_en_r  <= SIM_RST_PAGE1[SIM_BIT_PLL_EN];
      cksrc_r   <= SIM_RST_PAGE1[SIM_BIT_CKSRC];
    end
    else if (CLK_EN)
    begin
      if (PROG_SESSION)
      begin
        vco_gnd_r <= 1'b1;
        pll_en_r  <= 1'b1;
        cksrc_r   <= 1'b1;
      end
      else if (p1_wr)
      begin
        vco_gnd_r <= wd[SIM_BIT_VCO_GND];
        pll_en_r  <= pll_en_w;
        cksrc_r   <= cksrc_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      SUPPLY_IRQ      <= 1'b0;
      CLOCK_IRQ       <= 1'b0;
      WAKE_REQ        <= 1'b0;
      PLL_ENABLE      <= 1'b0;
      VCO_GROUNDED    <= 1'b0;
      PLL_CLK_SELECT  <= 1'b0;
      SAFE_OSC_SELECT <= 1'b0;
    end
    else if (CLK_EN)
    begin
      SUPPLY_IRQ      <= sw_req;
      CLOCK_IRQ       <= cf_req;
      WAKE_REQ        <= wake_nxt;
      PLL_ENABLE      <= guard_on;
      VCO_GROUNDED    <= vco_gnd_r;
      PLL_CLK_SELECT  <= cksrc_r;
      SAFE_OSC_SELECT <= safe_take;
    end
  end

endmodule : sysint_monitor

/* verif/sim_check_monitor.sv */
// checker for the system integrity monitor ports: bus handshake, pll interlocks, irq clearing
// assumes CLK_EN is held high, so no state is frozen while it watches
`timescale 1ns/1ps
module sim_check
  import sysint_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic       AVS_READ,
  input wire logic       AVS_WRITE,
  input wire logic       AVS_WAITREQUEST,
  input wire logic [1:0] AVS_RESPONSE,
  input wire logic       SUPPLY_BELOW,
  input wire logic       SW_IRQ_ACK,
  input wire logic       CPU_HALT,
  input wire logic       ACTIVE_HALT,
  input wire logic       PROG_SESSION,
  input wire logic       SUPPLY_IRQ,
  input wire logic       CLOCK_IRQ,
  input wire logic       PLL_ENABLE,
  input wire logic       PLL_CLK_SELECT,
  input wire logic       SAFE_OSC_SELECT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // comparator settled and no write that could re-arm the warning
  sequence s_quiet;
    (!AVS_WRITE && $stable(SUPPLY_BELOW)) [*4];
  endsequence
  chk_wait_one: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  chk_ack_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chk_unmapped_resp: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS != SIM_OFS_CTRL
    && AVS_ADDRESS != SIM_OFS_EVENT && AVS_ADDRESS != SIM_OFS_STRAP |-> AVS_RESPONSE == 2'b10)
    else $error("unmapped read not flagged");
  chk_sel_needs_pll: assert property (PLL_CLK_SELECT && !$past(CPU_HALT) |-> PLL_ENABLE)
    else $error("pll clock picked while pll off");
  chk_prog_forces: assert property ((PROG_SESSION && !CPU_HALT) [*3] |-> PLL_ENABLE && PLL_CLK_SELECT)
    else $error("programming session not forcing pll");
  chk_ack_clears: assert property (s_quiet ##0 SW_IRQ_ACK |=> ##1 !SUPPLY_IRQ)
    else $error("warning pending kept after service entry");
  chk_halt_no_safe: assert property ((CPU_HALT && !ACTIVE_HALT) [*2] |-> !SAFE_OSC_SELECT)
    else $error("safe oscillator active in halt");
  chk_pll_off: assert property ((!PLL_ENABLE && !CPU_HALT) [*3] |-> !CLOCK_IRQ && !SAFE_OSC_SELECT)
    else $error("clock guard active with pll off");
endmodule : sim_check
bind sysint_monitor sim_check u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_RESPONSE(AVS_RESPONSE), .SUPPLY_BELOW(SUPPLY_BELOW), .SW_IRQ_ACK(SW_IRQ_ACK),
  .CPU_HALT(CPU_HALT), .ACTIVE_HALT(ACTIVE_HALT), .PROG_SESSION(PROG_SESSION),
  .SUPPLY_IRQ(SUPPLY_IRQ), .CLOCK_IRQ(CLOCK_IRQ), .PLL_ENABLE(PLL_ENABLE),
  .PLL_CLK_SELECT(PLL_CLK_SELECT), .SAFE_OSC_SELECT(SAFE_OSC_SELECT));

/* verif/sysint_monitor_tb_top.sv */
// self-checking bench for the system integrity monitor: bus tasks, random supply toggles
// assumes the package, the monitor and its checker are compiled before this file
`timescale 1ns/1ps
module sysint_monitor_tb_top;
  import sysint_pkg::*;
  logic        clk, nrst, rd, wr, below, lost, lock, uv, wd, prog, mask, ack, cwait, halt;
  logic        wreq, sirq, cirq, wake, pll_en, vco, psel, safe, ahalt, long_opt;
  logic [3:0]  addr;
  logic [31:0] wdat, rdata;
  logic [1:0]  resp, rs;
  logic [7:0]  q;
  int          seed, n_mismatch, n_compared, i;
  // short reset delays keep the run brief
  sysint_monitor #(.RST_DELAY_SHORT(4), .RST_DELAY_LONG(8)) dut (.CLK_SYS(clk), .NRST(nrst),
    .CLK_EN(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp),
    .SUPPLY_BELOW(below), .MAIN_CLK_LOST(lost), .PLL_LOCKED(lock), .UV_RESET_EVT(uv),
    .WD_RESET_EVT(wd), .LONG_DELAY_OPT(long_opt), .PROG_SESSION(prog), .CPU_IRQ_MASK(mask),
    .SW_IRQ_ACK(ack), .CPU_WAIT(cwait), .CPU_HALT(halt), .ACTIVE_HALT(ahalt), .SUPPLY_IRQ(sirq),
    .CLOCK_IRQ(cirq), .WAKE_REQ(wake), .PLL_ENABLE(pll_en), .VCO_GROUNDED(vco),
    .PLL_CLK_SELECT(psel), .SAFE_OSC_SELECT(safe));
  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] p0(input logic ie, swf, uvf, cfie, sf, wdf);
    return {1'b0, ie, swf, uvf, 1'b0, cfie, sf, wdf};
  endfunction : p0
  function automatic logic [7:0] p1(input logic vg, lk, en, sel);
    return {2'b10, vg, lk, en, 1'b0, sel, 1'b0};
  endfunction : p1
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // holds the request until waitrequest is sampled low, then takes data and releases
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) cmp(8'h01, 8'h00);
    q = rdata[7:0];
    rs = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wt(input int s, input logic v);
    logic x;
    int   n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      x = (s == 0) ? sirq : (s == 1) ? cirq : (s == 2) ? wake : safe;
    end while (x !== v && n < 12);
    cmp({7'h0, x}, {7'h0, v});
  endtask : wt
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) ack <= 1'b1; else if (k == 1) uv <= 1'b1; else wd <= 1'b1;
    @(posedge clk);
    {ack, uv, wd} <= 3'b000;
  endtask : pulse
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #5000000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    seed = 32'h1f1c194c;
    {nrst, rd, wr, below, lost, uv, wd, prog, mask, ack, cwait, halt, ahalt, long_opt} = '0;
    addr = 4'h0;
    wdat = 32'h0;
    lock = 1'($random(seed));
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    bus(1, SIM_OFS_CTRL, 8'h80);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, p1(0, lock, 0, 0));
    bus(1, SIM_OFS_CTRL, 8'h00);
    bus(1, SIM_OFS_CTRL, 8'h00);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, 8'h00);
    bus(0, 4'hc, 8'h00);
    cmp({6'h0, rs}, 8'h02);
    cmp(q, 8'h00);
    bus(0, SIM_OFS_STRAP, 8'h00);
    cmp(q, 8'h00);
    pulse(2);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, p0(0, 0, 0, 0, 0, 1));
    pulse(1);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, p0(0, 0, 1, 0, 0, 0));
    pulse(2);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, p0(0, 0, 1, 0, 0, 1));
    bus(1, SIM_OFS_CTRL, 8'h00);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, 8'h00);
    bus(1, SIM_OFS_CTRL, 8'h40);
    wt(0, 1);
    pulse(0);
    wt(0, 0);
    for (i = 0; i < 8; i++)
    begin
      cwait <= 1'($random(seed));
      below <= !below;
      wt(0, 1);
      if (cwait === 1'b1) wt(2, 1);
      bus(0, SIM_OFS_CTRL, 8'h00);
      cmp(q, p0(1, below, 0, 0, 0, 0));
      pulse(0);
      wt(0, 0);
      repeat (1 + ($random(seed) & 3)) @(posedge clk);
    end
    cwait <= 1'b0;
    bus(1, SIM_OFS_CTRL, 8'h00);
    below <= !below;
    repeat (4) @(posedge clk);
    cmp({7'h0, sirq}, 8'h00);
    repeat (4) @(posedge clk);
    bus(1, SIM_OFS_CTRL, 8'h40);
    wt(0, 1);
    pulse(0);
    wt(0, 0);
    bus(1, SIM_OFS_CTRL, 8'h80);
    bus(1, SIM_OFS_CTRL, 8'h8a);
    @(posedge clk);
    cmp({6'h0, pll_en, psel}, 8'h03);
    bus(1, SIM_OFS_CTRL, 8'h82);
    @(posedge clk);
    cmp({6'h0, pll_en, psel}, 8'h03);
    bus(1, SIM_OFS_CTRL, 8'ha8);
    @(posedge clk);
    cmp({5'h0, vco, pll_en, psel}, 8'h06);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q, p1(1, lock, 1, 0));
    bus(1, SIM_OFS_CTRL, 8'h08);
    bus(1, SIM_OFS_CTRL, 8'h44);
    lost <= 1'b1;
    wt(3, 1);
    wt(1, 1);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q & 8'h02, 8'h02);
    lost <= 1'b0;
    wt(3, 0);
    bus(0, SIM_OFS_CTRL, 8'h00);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q & 8'h02, 8'h00);
    bus(1, SIM_OFS_CTRL, 8'h80);
    bus(1, SIM_OFS_CTRL, 8'h44);
    lost <= 1'b1;
    repeat (6) @(posedge clk);
    bus(0, SIM_OFS_CTRL, 8'h00);
    cmp(q & 8'h02, 8'h00);
    bus(1, SIM_OFS_CTRL, 8'h80);
    bus(1, SIM_OFS_CTRL, 8'h08);
    bus(1, SIM_OFS_CTRL, 8'h44);
    wt(3, 1);
    halt <= 1'b1;
    wt(3, 0);
    pulse(0);
    wt(2, 0);
    below <= !below;
    wt(2, 1);
    pulse(0);
    wt(2, 0);
    ahalt <= 1'b1;
    wt(2, 1);
    {halt, ahalt} <= 2'b00;
    wt(3, 1);
    prog <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({5'h0, vco, pll_en, psel}, 8'h07);
    bus(0, SIM_OFS_STRAP, 8'h00);
    cmp(q, 8'h02);
    test_done;
  end
endmodule : sysint_monitor_tb_top
